//--- logic/pcs_pkg.sv
// Shared constants for the program counter sequencer and its return stack
`default_nettype none
package pcs_pkg;

   // ****************************************************
   // Program counter widths per memory size
   // ****************************************************
   localparam int PC_W_512 = 9;                    // 512-word parts
   localparam int PC_W_1K  = 10;                   // 1K-word part
   localparam int PC_W_2K  = 11;                   // 2K-word part, also full stack width

   // ****************************************************
   // Vectors, held at full 11-bit width and cut to PC_W
   // ****************************************************
   localparam logic [10:0] RST_VEC_512 = 11'h1FF;  // Last word of 512-word memory
   localparam logic [10:0] RST_VEC_1K  = 11'h3FF;  // Last word of 1K-word memory
   localparam logic [10:0] RST_VEC_2K  = 11'h7FF;  // Last word of 2K-word memory
   localparam logic [10:0] HW_VEC      = 11'h008;  // Hardware interrupt entry
   localparam logic [10:0] SW_VEC      = 11'h002;  // Software interrupt entry

   // ****************************************************
   // Instruction word layout
   // ****************************************************
   localparam int          INSTR_W      = 13;      // One word per instruction
   localparam int          OPC_HI       = 12;      // Top of branch opcode field
   localparam int          OPC_LO       = 10;      // Bottom of branch opcode field
   localparam int          TGT_W        = 10;      // In-page target width
   localparam int          PAGE_BIT     = 2;       // Page select bit in the high buffer
   localparam logic [2:0]  OPC_CALL     = 3'h4;    // Subroutine call
   localparam logic [2:0]  OPC_JUMP     = 3'h5;    // Direct jump
   localparam logic [12:0] INSTR_RET    = 13'h0010;// Return from subroutine
   localparam logic [12:0] INSTR_RETI   = 13'h0011;// Return from interrupt
   localparam logic [12:0] INSTR_SWINT  = 13'h0012;// Software interrupt

   // ****************************************************
   // Stack and timing
   // ****************************************************
   localparam int STACK_DEPTH    = 5;                               // Return levels
   localparam int INSTR_CYC_NS   = 100;                             // Instruction cycle
   localparam int CLK_PERIOD_NS  = 5;                               // Core clock period
   localparam int INSTR_CYC_CLKS = INSTR_CYC_NS / CLK_PERIOD_NS;   // Clocks per cycle

   // Sequencer states, one-hot
   typedef enum logic [1:0] {
      SEQ_RUN   = 2'b01,                           // Executing the fetched word
      SEQ_FLUSH = 2'b10                            // Second cycle of a flow change
   } pcs_state_t;

endpackage
`default_nettype wire

//--- logic/pcs_stack_if.sv
// Push, pop and data lines between the sequencer and its return stack
`timescale 1ns/100ps
`default_nettype none
interface pcs_stack_if #(parameter int W = 11);
   logic         push;       // Store push_data on top, one-cycle strobe
   logic         pop;        // Drop the top entry, one-cycle strobe
   logic [W-1:0] push_data;  // Return address to store
   logic [W-1:0] top_data;   // Most recently pushed entry

   modport seq   (output push, output pop, output push_data, input top_data);
   modport store (input push, input pop, input push_data, output top_data);
endinterface
`default_nettype wire

//--- logic/pcs_stack.sv
// Circular hardware return-address stack
`timescale 1ns/100ps
`default_nettype none
module pcs_stack
   import pcs_pkg::*;
#(
   parameter int DEPTH = STACK_DEPTH,
   parameter int W     = PC_W_2K
) (
   input wire logic   core_clk,
   input wire logic   nrst,
   pcs_stack_if.store stk
);

   localparam int P_W = $clog2(DEPTH);
   localparam logic [P_W-1:0] P_LAST = P_W'(DEPTH - 1);
   localparam logic [P_W-1:0] P_ZERO = '0;

   logic [P_W-1:0] ptr_reg;             // Next free slot
   logic [P_W-1:0] ptr_next;
   logic [P_W-1:0] top_idx;             // Slot of the newest entry
   logic [W-1:0]   entry_reg [DEPTH];   // Stored return addresses

   // ****************************************************
   // Pointer movement
   // ****************************************************
   // Wrapping pointer: a sixth push lands on the oldest slot, see RL14
   always_comb begin
      ptr_next = ptr_reg;
      if (stk.push) begin
         ptr_next = (ptr_reg == P_LAST) ? P_ZERO : P_W'(ptr_reg + 1'b1);
      end else if (stk.pop) begin
         ptr_next = top_idx;
      end
   end

   assign top_idx      = (ptr_reg == P_ZERO) ? P_LAST : P_W'(ptr_reg - 1'b1);
   assign stk.top_data = entry_reg[top_idx];

   // Pointer register
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ptr_reg <= '0;
      end else begin
         ptr_ptr_update: ptr_reg <= ptr_next;
      end
   end

   // ****************************************************
   // Storage, five levels deep
   // ****************************************************
   // One write port per slot; no reset needed since pops of empty slots are undefined anyway
   for (genvar i = 0; i < DEPTH; i++) begin : g_slot
      always_ff @(posedge core_clk) begin
         if (stk.push && ptr_reg == P_W'(i)) begin
            entry_reg[i] <= stk.push_data;  // see RL10
         end
      end
   end

   // ****************************************************
   // Checks
   // ****************************************************
   a_push_then_top: assert property (@(posedge core_clk) disable iff (!nrst) // see RL14
      stk.push |=> stk.top_data == $past(stk.push_data))
      else $error("pushed address not on top of stack");

   a_ptr_in_range: assert property (@(posedge core_clk) disable iff (!nrst) // see RL10
      ptr_reg <= P_LAST)
      else $error("stack pointer beyond five levels");

endmodule
`default_nettype wire

//--- logic/pcs_sequencer.sv
// Program counter and instruction sequencer of the 8-bit controller core
//
// Behaviour
// RL1 - PC is 9, 10 or 11 bits
// RL2 - Reset loads last program memory address
// RL3 - Hardware interrupt jumps to 008h
// RL4 - Software interrupt instruction jumps to 002h
// RL5 - Call and jump carry 10-bit target
// RL6 - 2K part: PC bit 10 from buffer bit 2
// RL7 - Software sets page bit before call/jump
// RL8 - Returns restore full PC from stack
// RL9 - One cycle per instruction, branches take two
// RL10 - Five-level hardware return stack
// RL11 - Instructions are single 13-bit words
// RL12 - Low reset pin holds device in reset
// RL13 - RC mode: oscillator pin toggles per cycle
// RL14 - Push next address; overflow overwrites oldest
// RL15 - Otherwise PC increments and wraps
`timescale 1ns/100ps
`default_nettype none
module pcs_sequencer
   import pcs_pkg::*;
#(
   parameter int          PC_W     = PC_W_2K,        // see RL1
   parameter logic [10:0] RST_VEC  = RST_VEC_2K,     // Must match PC_W
   parameter int          CYC_CLKS = INSTR_CYC_CLKS  // Core clocks per instruction cycle
) (
   input  wire logic              core_clk,
   input  wire logic              nrst,
   input  wire logic              clk_en,
   input  wire logic              reset_n_pin,
   input  wire logic [INSTR_W-1:0] instr_word,
   input  wire logic [2:0]        pc_high_buffer,
   input  wire logic              irq_req,
   input  wire logic              rc_mode,
   output var  logic [PC_W-1:0]   prog_addr,
   output var  logic              flush_cycle,
   output var  logic              osc_out_pin
);

   // ****************************************************
   // Local constants
   // ****************************************************
   localparam int PH_W = $clog2(CYC_CLKS + 1);
   localparam logic [PH_W-1:0] PH_LAST = PH_W'(CYC_CLKS - 1);   // End of the cycle
   localparam logic [PH_W-1:0] PH_HALF = PH_W'(CYC_CLKS / 2);   // Clock output falls here
   localparam logic [PH_W-1:0] PH_ZERO = '0;
   localparam logic [PC_W-1:0] PC_RST  = PC_W'(RST_VEC);
   localparam logic [PC_W-1:0] PC_HW   = PC_W'(HW_VEC);
   localparam logic [PC_W-1:0] PC_SW   = PC_W'(SW_VEC);

   // ****************************************************
   // Declarations
   // ****************************************************
   logic [PC_W-1:0] pc_reg;       // Address being fetched
   logic [PC_W-1:0] pc_next;
   logic [PC_W-1:0] pc_inc;       // Address of the following word
   logic [PC_W-1:0] branch_tgt;   // Paged call or jump target
   logic [10:0]     tgt_full;     // Target before cutting to PC_W
   pcs_state_t      state_reg;    // Run or flush
   pcs_state_t      state_next;
   logic [PH_W-1:0] phase_reg;    // Position inside the instruction cycle
   logic [PH_W-1:0] phase_next;
   logic            osc_reg;      // RC-mode clock output
   logic            flush_reg;    // Dead-cycle flag, kept in its own flop for the port
   logic            boundary;     // Last clock of the instruction cycle
   logic            step;         // Cycle ends with the core out of reset
   logic            is_call;
   logic            is_jump;
   logic            is_ret;
   logic            is_swint;
   logic            push_c;
   logic            pop_c;

   pcs_stack_if #(.W(PC_W)) stk ();

   // ****************************************************
   // Return stack
   // ****************************************************
   pcs_stack #(
      .DEPTH (STACK_DEPTH),
      .W     (PC_W)
   ) u_stack (
      .core_clk (core_clk),
      .nrst     (nrst),
      .stk      (stk.store)
   );

   // ****************************************************
   // Decode
   // ****************************************************
   // The whole 13-bit word is one instruction, see RL11
   assign is_call  = (instr_word[OPC_HI:OPC_LO] == OPC_CALL);
   assign is_jump  = (instr_word[OPC_HI:OPC_LO] == OPC_JUMP);
   assign is_ret   = (instr_word == INSTR_RET) || (instr_word == INSTR_RETI);
   assign is_swint = (instr_word == INSTR_SWINT);

   // Only 10 target bits in the word; page bit supplied by software, see RL5 RL6 RL7
   assign tgt_full   = {pc_high_buffer[PAGE_BIT], instr_word[TGT_W-1:0]};
   assign branch_tgt = PC_W'(tgt_full);
   assign pc_inc     = PC_W'(pc_reg + 1'b1);

   assign boundary = (phase_reg == PH_LAST);
   assign step     = clk_en && reset_n_pin && boundary;

   // ****************************************************
   // Next program counter
   // ****************************************************
   // Interrupt beats the fetched word; the interrupted word runs after return
   always_comb begin
      pc_next    = pc_inc;          // see RL15
      state_next = SEQ_RUN;
      push_c     = 1'b0;
      pop_c      = 1'b0;
      case (state_reg)
         SEQ_FLUSH: begin
            // Dead cycle: hold the new target so it executes next, see RL9
            pc_next = pc_reg;
         end
         default: begin
            if (irq_req) begin
               push_c     = 1'b1;       // see RL14
               pc_next    = PC_HW;      // see RL3
               state_next = SEQ_FLUSH;
            end else if (is_call) begin
               push_c     = 1'b1;       // see RL14
               pc_next    = branch_tgt; // see RL6
               state_next = SEQ_FLUSH;
            end else if (is_jump) begin
               pc_next    = branch_tgt; // see RL5
               state_next = SEQ_FLUSH;
            end else if (is_ret) begin
               pop_c      = 1'b1;
               pc_next    = stk.top_data; // see RL8
               state_next = SEQ_FLUSH;
            end else if (is_swint) begin
               push_c     = 1'b1;
               pc_next    = PC_SW;      // see RL4
               state_next = SEQ_FLUSH;
            end
         end
      endcase
   end

   // Return address is the interrupted word itself, or the word after a call or software interrupt
   assign stk.push_data = irq_req ? pc_reg : pc_inc;
   assign stk.push      = step && push_c;
   assign stk.pop       = step && pop_c;

   // ****************************************************
   // Program counter and state
   // ****************************************************
   // A low reset pin acts on any enabled clock, not only at cycle ends
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pc_reg    <= PC_RST;           // see RL2
         state_reg <= SEQ_RUN;
         flush_reg <= 1'b0;
      end else if (clk_en) begin
         if (!reset_n_pin) begin
            pc_reg    <= PC_RST;        // see RL12
            state_reg <= SEQ_RUN;
            flush_reg <= 1'b0;
         end else if (boundary) begin
            pc_reg    <= pc_next;
            state_reg <= state_next;
            // Registered here so the port has no decode logic behind it, see RL9
            flush_reg <= (state_next == SEQ_FLUSH);
         end
      end
   end

   // ****************************************************
   // Cycle phase and clock output
   // ****************************************************
   always_comb begin
      phase_next = boundary ? PH_ZERO : PH_W'(phase_reg + 1'b1);
      if (!reset_n_pin) begin
         phase_next = PH_ZERO;
      end
   end

   // Square wave at the instruction rate, high in the first half; idle low otherwise
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         phase_reg <= '0;
         osc_reg   <= 1'b0;
      end else if (clk_en) begin
         phase_reg <= phase_next;
         osc_reg   <= rc_mode && (phase_next < PH_HALF); // see RL13
      end
   end

   assign prog_addr   = pc_reg;
   assign flush_cycle = flush_reg;
   assign osc_out_pin = osc_reg;

   // ****************************************************
   // Checks
   // ****************************************************
   sequence s_run_end;
      step && state_reg == SEQ_RUN;
   endsequence

   sequence s_irq_taken;
      s_run_end ##0 irq_req;
   endsequence

   sequence s_call_taken;
      s_run_end ##0 (!irq_req && is_call);
   endsequence

   sequence s_ret_taken;
      s_run_end ##0 (!irq_req && is_ret);
   endsequence

   sequence s_plain_word;
      s_run_end ##0 (!irq_req && !is_call && !is_jump && !is_ret && !is_swint);
   endsequence

   a_reset_vector: assert property (@(posedge core_clk) disable iff (!nrst) // see RL12
      clk_en && !reset_n_pin |=> prog_addr == PC_RST && !flush_cycle)
      else $error("reset pin did not load reset vector");

   a_hw_vector: assert property (@(posedge core_clk) disable iff (!nrst) // see RL3
      s_irq_taken |=> prog_addr == PC_HW && flush_cycle)
      else $error("interrupt did not reach 008h");

   a_sw_vector: assert property (@(posedge core_clk) disable iff (!nrst) // see RL4
      s_run_end ##0 (!irq_req && is_swint) |=> prog_addr == PC_SW)
      else $error("software interrupt did not reach 002h");

   a_call_paged: assert property (@(posedge core_clk) disable iff (!nrst) // see RL6
      s_call_taken |=> prog_addr == PC_W'({$past(pc_high_buffer[PAGE_BIT]),
                                           $past(instr_word[TGT_W-1:0])}))
      else $error("call target not paged correctly");

   a_ret_restore: assert property (@(posedge core_clk) disable iff (!nrst) // see RL8
      s_ret_taken |=> prog_addr == $past(stk.top_data))
      else $error("return did not restore stacked address");

   a_two_cycles: assert property (@(posedge core_clk) disable iff (!nrst) // see RL9
      flush_cycle && step |=> !flush_cycle && $past(prog_addr) == prog_addr)
      else $error("flow change not exactly two cycles");

   a_seq_incr: assert property (@(posedge core_clk) disable iff (!nrst) // see RL15
      s_plain_word |=> prog_addr == PC_W'($past(prog_addr) + 1'b1) && !flush_cycle)
      else $error("program counter did not increment");

   a_osc_rate: assert property (@(posedge core_clk) disable iff (!nrst) // see RL13
      clk_en && boundary && reset_n_pin |=> osc_out_pin == $past(rc_mode))
      else $error("clock output wrong at cycle start");

endmodule
`default_nettype wire

//--- verif/pcs_prog_mem.sv
// Behavioural program memory that feeds the sequencer
`timescale 1ns/100ps
`default_nettype none
module pcs_prog_mem
   import pcs_pkg::*;
#(
   parameter int AW = PC_W_2K                 // Address width of the part
) (
   input  wire logic [AW-1:0]      addr,
   output var  logic [INSTR_W-1:0] data
);
   // Whole words only, loaded by the bench before reset ends; word 7FFh is cleared again mid-run
   logic [INSTR_W-1:0] mem [0:(1<<AW)-1];

   // Read is combinational: the word follows the address in the same cycle
   assign data = mem[addr];
endmodule
`default_nettype wire

//--- verif/program_counter_sequencer_tb.sv
// Self-checking bench for the program counter sequencer
`timescale 1ns/100ps
`default_nettype none
module program_counter_sequencer_tb
   import pcs_pkg::*;
;
   // ****************************************************
   // Signals
   // ****************************************************
   localparam int CYC = 2;                    // Short instruction cycle keeps runs brief
   typedef struct packed {
      logic [10:0] addr;                      // Expected program counter
      logic        flush;                     // Expected dead-cycle flag
   } pcs_tb_note_t;
   logic               core_clk, nrst, clk_en, reset_n_pin, irq_req, rc_mode;
   logic [INSTR_W-1:0] instr_word;
   logic [2:0]         pc_high_buffer;
   logic [10:0]        prog_addr;
   logic               flush_cycle, osc_out_pin;
   pcs_tb_note_t       note_q[$];             // Expectations waiting for the monitor
   int                 num_errors = 0;
   int                 cmp_count  = 0;
   logic [31:0]        rng_state  = 32'hEB25766A;

   // ****************************************************
   // Design, memory and clock
   // ****************************************************
   pcs_sequencer #(.PC_W(PC_W_2K), .RST_VEC(RST_VEC_2K), .CYC_CLKS(CYC)) dut (
      .core_clk(core_clk), .nrst(nrst), .clk_en(clk_en), .reset_n_pin(reset_n_pin),
      .instr_word(instr_word), .pc_high_buffer(pc_high_buffer), .irq_req(irq_req),
      .rc_mode(rc_mode), .prog_addr(prog_addr), .flush_cycle(flush_cycle),
      .osc_out_pin(osc_out_pin));
   pcs_prog_mem #(.AW(PC_W_2K)) u_mem (.addr(prog_addr), .data(instr_word));

   // Free running core clock
   always #2.5 core_clk = ~core_clk;

   // ****************************************************
   // Tasks
   // ****************************************************
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction

   // Address of the k-th link of the nested call chain
   function automatic logic [10:0] ak(input int k);
      return 11'(32'h100 + k * 16);
   endfunction

   task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One instruction cycle, entered just after a cycle-end edge
   task automatic cyc(input logic [10:0] a, input logic f, input logic pg, input logic irq);
      rng_state = xs(rng_state);
      pc_high_buffer = {pg, rng_state[1:0]};
      irq_req = irq;
      note_q.push_back({a, f});
      @(posedge core_clk);
      @(posedge core_clk);
      #1;
   endtask

   // RC option gives one square period per instruction cycle, crystal keeps it low
   task automatic osc(input logic mode);
      int hi;
      int chg;
      logic last;
      hi = 0;
      chg = 0;
      rc_mode = mode;
      repeat (4) @(posedge core_clk);
      #1 last = osc_out_pin;
      for (int i = 0; i < 8; i++) begin
         @(posedge core_clk);
         #1 hi += int'(osc_out_pin === 1'b1);
         chg += int'(osc_out_pin !== last);
         last = osc_out_pin;
      end
      check("osc high count", 11'(hi), mode ? 11'h004 : 11'h000);
      check("osc edge count", 11'(chg), mode ? 11'h008 : 11'h000);
   endtask

   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ****************************************************
   // Stimulus
   // ****************************************************
   initial begin
      logic [10:0] t;
      core_clk = 1'b0; nrst = 1'b0; clk_en = 1'b1; reset_n_pin = 1'b1;
      irq_req = 1'b0; rc_mode = 1'b1; pc_high_buffer = 3'h0;
      // Plain words everywhere, then a program that visits every flow change
      for (int i = 0; i < 2048; i++) u_mem.mem[i] = 13'h0000;
      u_mem.mem[11'h7FF] = {OPC_JUMP, 10'h100};
      for (int k = 0; k < 6; k++) begin
         t = ak(k + 1);
         u_mem.mem[ak(k)] = {OPC_CALL, t[9:0]};
      end
      u_mem.mem[ak(6)] = INSTR_RET;
      for (int k = 2; k < 6; k++) u_mem.mem[ak(k) + 11'h001] = INSTR_RET;
      u_mem.mem[ak(1) + 11'h001] = {OPC_CALL, 10'h100};
      u_mem.mem[11'h500] = INSTR_SWINT;
      u_mem.mem[11'h002] = INSTR_RET;
      u_mem.mem[11'h502] = INSTR_RET;
      u_mem.mem[11'h113] = {OPC_JUMP, 10'h3FE};
      u_mem.mem[11'h008] = INSTR_RETI;
      repeat (2) @(posedge core_clk);
      #1 nrst = 1'b1;
      cyc(11'h7FF, 1'b0, 1'b0, 1'b0);
      // Six nested calls overflow five levels; five returns come back newest first
      cyc(ak(0), 1'b1, 1'b0, 1'b0);
      cyc(ak(0), 1'b0, 1'b0, 1'b0);
      for (int k = 1; k < 7; k++) begin
         cyc(ak(k), 1'b1, 1'b0, 1'b0);
         cyc(ak(k), 1'b0, 1'b0, 1'b0);
      end
      for (int k = 5; k > 0; k--) begin
         cyc(ak(k) + 11'h001, 1'b1, 1'b0, 1'b0);
         cyc(ak(k) + 11'h001, 1'b0, k == 1, 1'b0);
      end
      $display("call chain test done");
      cyc(11'h500, 1'b1, 1'b0, 1'b0);
      cyc(11'h500, 1'b0, 1'b0, 1'b0);
      cyc(11'h002, 1'b1, 1'b0, 1'b0);
      cyc(11'h002, 1'b0, 1'b0, 1'b0);
      cyc(11'h501, 1'b1, 1'b0, 1'b0);
      cyc(11'h501, 1'b0, 1'b0, 1'b0);
      cyc(11'h502, 1'b0, 1'b0, 1'b0);
      cyc(11'h112, 1'b1, 1'b0, 1'b0);
      cyc(11'h112, 1'b0, 1'b0, 1'b0);
      // Request held through the dead cycle must not be taken twice
      cyc(11'h113, 1'b0, 1'b0, 1'b1);
      cyc(11'h008, 1'b1, 1'b0, 1'b1);
      cyc(11'h008, 1'b0, 1'b0, 1'b0);
      cyc(11'h113, 1'b1, 1'b0, 1'b0);
      cyc(11'h113, 1'b0, 1'b1, 1'b0);
      u_mem.mem[11'h7FF] = 13'h0000;
      cyc(11'h7FE, 1'b1, 1'b0, 1'b0);
      cyc(11'h7FE, 1'b0, 1'b0, 1'b0);
      cyc(11'h7FF, 1'b0, 1'b0, 1'b0);
      cyc(11'h000, 1'b0, 1'b0, 1'b0);
      $display("flow change test done");
      // A frozen clock enable must not advance the cycle
      rng_state = xs(rng_state);
      clk_en = 1'b0;
      repeat (1 + int'(rng_state[1:0])) @(posedge core_clk);
      #1 clk_en = 1'b1;
      cyc(11'h001, 1'b0, 1'b0, 1'b0);
      // External pin reset mid-run restarts at the reset vector
      reset_n_pin = 1'b0;
      repeat (2) @(posedge core_clk);
      #1 reset_n_pin = 1'b1;
      cyc(11'h7FF, 1'b0, 1'b0, 1'b0);
      cyc(11'h000, 1'b0, 1'b0, 1'b0);
      $display("reset pin test done");
      osc(1'b1);
      osc(1'b0);
      $display("oscillator test done");
      check("notes left", 11'(note_q.size()), 11'h000);
      tally_and_finish();
   end

   // ****************************************************
   // Monitor: compares each settled cycle with the oldest note
   // ****************************************************
   initial begin
      pcs_tb_note_t n;
      forever begin
         @(posedge core_clk);
         #2;
         if (note_q.size() > 0) begin
            n = note_q.pop_front();
            check("prog_addr", prog_addr, n.addr);
            check("flush_cycle", {10'h000, flush_cycle}, {10'h000, n.flush});
         end
      end
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge core_clk);
      num_errors++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
